/* File: hdl/sss_regs.vh */
// Register map, field positions and state codes of the scan sequencer
`ifndef SSS_REGS_VH
`define SSS_REGS_VH

// Avalon-MM byte offsets
`define SSS_ADDR_W        4
`define SSS_OFS_CTRL      4'h0
`define SSS_OFS_STATUS    4'h4
`define SSS_OFS_COUNT     4'h8

// Control register
`define SSS_CTRL_EN_BIT   0
`define SSS_CTRL_RST      8'h01

// Status register fields
`define SSS_ST_STATE_LSB  0
`define SSS_ST_STATE_MSB  2
`define SSS_ST_SLOT_LSB   4
`define SSS_ST_SLOT_MSB   6
`define SSS_ST_MODE_BIT   8
`define SSS_ST_SEL_LSB    12
`define SSS_ST_SEL_MSB    14
`define SSS_ST_DONE_BIT   16
`define SSS_ST_ERR_BIT    17
`define SSS_ST_INH_BIT    18
`define SSS_ST_EOSN_LSB   20
`define SSS_ST_EOSN_MSB   23

// Sequencer states, one-hot
`define SSS_S_IDLE        3'h1
`define SSS_S_RUN         3'h2
`define SSS_S_END         3'h4

// Mode line levels
`define SSS_MODE_SEQ      1'b0
`define SSS_MODE_SIM      1'b1

// Pixel cycles allowed without a new end-of-scan while ending
`define SSS_EOS_WAIT      4'h2

`endif

/* File: hdl/sss_scan_sequencer.v */
// Eight-channel sensor scan sequencer with Avalon-MM status and control
`timescale 1ns/1ps
`default_nettype none
`include "sss_regs.vh"

// Function
// - Digital 8:1 selector plus analogue selector address
// - Route start, end-of-scan, pixel clock per channel
// - Analogue address picks channel for video output
// - Sequential: sequencer idle, selects drive addresses
// - Simultaneous: selects set number of active sensors
// - Pixel cycles begin only after scan start
// - Each cycle clocks every active sensor once
// - Sample start channel end-of-scan once per cycle
// - Start channel end-of-scan inhibits further storage
// - Success only after all active sensors report
// - Accept reports in channel order across cycles
// - Success: one end pulse per active channel
// - Missing report: pulses stop before that channel
// - Consecutive sensors offset by one pixel slot
// - Latch mode and selects on delayed strobe
// - Front end supplies main and secondary clock
// - End-of-scan output from selected channel (sequential) or sequencer result
// - Both identification outputs held low
// - Mode 0 sequential code k; mode 1 simultaneous
// - Code k activates channels 1..k+1 only
// - Both ident low marks active eight-channel type
module sss_scan_sequencer #(
    parameter NCH     = 8,
    parameter SEL_W   = 3,
    parameter EOS_CW  = 4
) (
    // Clock and reset
    input  wire             sys_clk_i,
    input  wire             rst_b_i,
    // Front-end control
    input  wire             scan_start_i,
    input  wire             config_latch_strobe_i,
    input  wire             scan_mode_select_i,
    input  wire             channel_select_bit0_i,
    input  wire             channel_select_bit1_i,
    input  wire             channel_select_bit2_i,
    input  wire             secondary_clock_in_i,
    // Front-end status
    output reg              scan_end_out_n_o,
    output reg              data_store_inhibit_o,
    output reg              type_ident_bit0_o,
    output reg              type_ident_bit1_o,
    // Selector addresses
    output reg  [SEL_W-1:0] video_select_addr_o,
    // Sensor channels
    output reg  [NCH-1:0]   sensor_scan_begin_o,
    output reg  [NCH-1:0]   sensor_pixel_clock_o,
    input  wire [NCH-1:0]   sensor_scan_end_n_i,
    // Avalon-MM slave
    input  wire [`SSS_ADDR_W-1:0] avs_address_i,
    input  wire             avs_read_i,
    input  wire             avs_write_i,
    input  wire [31:0]      avs_writedata_i,
    input  wire [3:0]       avs_byteenable_i,
    output reg  [31:0]      avs_readdata_o,
    output reg              avs_waitrequest_o
);

    // Latched configuration and edge history
    reg             mode_l;
    reg [SEL_W-1:0] sel_l;
    reg             strobe_q;
    reg             start_q;
    reg             phi_q;
    reg [7:0]       ctrl;

    // Sequencer state
    reg [2:0]       state;
    reg [SEL_W-1:0] slot;
    reg [SEL_W-1:0] last_ch;
    reg [NCH-1:0]   start_pend;
    reg [SEL_W:0]   eos_cnt;
    reg [EOS_CW-1:0] miss_cnt;
    reg             got_eos;
    reg             done_ok;
    reg             done_err;
    reg [15:0]      seq_count;

    wire [SEL_W-1:0] sel_now = {channel_select_bit2_i,
                                channel_select_bit1_i,
                                channel_select_bit0_i};
    wire phi_rise   = secondary_clock_in_i & ~phi_q;
    wire phi_fall   = ~secondary_clock_in_i & phi_q;
    wire start_rise = scan_start_i & ~start_q;
    wire enable     = ctrl[`SSS_CTRL_EN_BIT];
    wire cyc_wrap   = phi_fall & (slot == last_ch);
    wire [SEL_W-1:0] eos_ch = eos_cnt[SEL_W-1:0];
    wire eos_here   = ~sensor_scan_end_n_i[slot];
    wire in_seq     = (state != `SSS_S_IDLE);

    // Edge history and configuration latch
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            strobe_q <= 1'b0;
            start_q  <= 1'b0;
            phi_q    <= 1'b0;
            mode_l   <= `SSS_MODE_SEQ;
            sel_l    <= {SEL_W{1'b0}};
        end else begin
            strobe_q <= config_latch_strobe_i;
            start_q  <= scan_start_i;
            phi_q    <= secondary_clock_in_i;
            if (config_latch_strobe_i && !strobe_q) begin
                mode_l <= scan_mode_select_i;
                sel_l  <= sel_now;
            end
        end
    end

    // Simultaneous-mode sequencer
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            state      <= `SSS_S_IDLE;
            slot       <= {SEL_W{1'b0}};
            last_ch    <= {SEL_W{1'b0}};
            start_pend <= {NCH{1'b0}};
            eos_cnt    <= {(SEL_W+1){1'b0}};
            miss_cnt   <= {EOS_CW{1'b0}};
            got_eos    <= 1'b0;
            done_ok    <= 1'b0;
            done_err   <= 1'b0;
            seq_count  <= 16'h0000;
        end else begin
            case (state)
                `SSS_S_IDLE: begin
                    slot <= {SEL_W{1'b0}};
                    // Sequential mode never leaves idle
                    if (enable && mode_l == `SSS_MODE_SIM &&
                            start_rise) begin
                        state    <= `SSS_S_RUN;
                        last_ch  <= sel_l;
                        eos_cnt  <= {(SEL_W+1){1'b0}};
                        miss_cnt <= {EOS_CW{1'b0}};
                        got_eos  <= 1'b0;
                        done_ok  <= 1'b0;
                        done_err <= 1'b0;
                        start_pend <= {NCH{1'b1}} >>
                                      (NCH - 1 - sel_l);
                    end
                end
                `SSS_S_RUN: begin
                    if (phi_fall) begin
                        start_pend[slot] <= 1'b0;
                        slot <= (slot == last_ch) ?
                                {SEL_W{1'b0}} : slot + 1'b1;
                    end
                    // Start channel observed once per pixel cycle
                    if (phi_rise && slot == {SEL_W{1'b0}} &&
                            eos_here) begin
                        state   <= `SSS_S_END;
                        eos_cnt <= {{SEL_W{1'b0}}, 1'b1};
                    end
                end
                `SSS_S_END: begin
                    if (phi_fall) begin
                        slot <= (slot == last_ch) ?
                                {SEL_W{1'b0}} : slot + 1'b1;
                    end
                    if (phi_rise && slot == eos_ch && eos_here &&
                            eos_cnt <= {1'b0, last_ch}) begin
                        eos_cnt <= eos_cnt + 1'b1;
                        got_eos <= 1'b1;
                    end
                    if (eos_cnt == {1'b0, last_ch} + 1'b1) begin
                        state     <= `SSS_S_IDLE;
                        done_ok   <= 1'b1;
                        seq_count <= seq_count + 1'b1;
                    end else if (cyc_wrap) begin
                        got_eos  <= 1'b0;
                        miss_cnt <= got_eos ? {EOS_CW{1'b0}} :
                                    miss_cnt + 1'b1;
                        // Give up when the expected channel stays silent
                        if (!got_eos &&
                                miss_cnt + 1'b1 >= `SSS_EOS_WAIT) begin
                            state     <= `SSS_S_IDLE;
                            done_err  <= 1'b1;
                            seq_count <= seq_count + 1'b1;
                        end
                    end
                end
                default: begin
                    state <= `SSS_S_IDLE;
                end
            endcase
        end
    end

    // Selector outputs, all registered
    integer i;
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            sensor_scan_begin_o  <= {NCH{1'b0}};
            sensor_pixel_clock_o <= {NCH{1'b0}};
            video_select_addr_o  <= {SEL_W{1'b0}};
            scan_end_out_n_o     <= 1'b1;
            data_store_inhibit_o <= 1'b0;
            type_ident_bit0_o    <= 1'b0;
            type_ident_bit1_o    <= 1'b0;
        end else begin
            type_ident_bit0_o <= 1'b0;
            type_ident_bit1_o <= 1'b0;
            data_store_inhibit_o <= (state == `SSS_S_END);
            if (!in_seq) begin
                // Sequential: all sensors run in parallel
                video_select_addr_o <= sel_l;
                for (i = 0; i < NCH; i = i + 1) begin
                    sensor_scan_begin_o[i] <= enable &&
                        mode_l == `SSS_MODE_SEQ && scan_start_i;
                    sensor_pixel_clock_o[i] <= enable &&
                        mode_l == `SSS_MODE_SEQ &&
                        secondary_clock_in_i;
                end
                scan_end_out_n_o <= (mode_l == `SSS_MODE_SEQ) ?
                    sensor_scan_end_n_i[sel_l] : 1'b1;
            end else begin
                video_select_addr_o <= slot;
                for (i = 0; i < NCH; i = i + 1) begin
                    // One clock per active sensor in its own slot
                    sensor_pixel_clock_o[i] <= (slot == i) &&
                        secondary_clock_in_i;
                    sensor_scan_begin_o[i] <= (slot == i) &&
                        start_pend[i] && state == `SSS_S_RUN;
                end
                // Forward each accepted end-of-scan as a pulse, the
                // start channel's included; tied to the same clock rise
                // that counts it, so a late report is never sent twice
                scan_end_out_n_o <= ~(phi_rise && eos_here &&
                    ((state == `SSS_S_RUN &&
                      slot == {SEL_W{1'b0}}) ||
                     (state == `SSS_S_END && slot == eos_ch &&
                      eos_cnt <= {1'b0, last_ch})));
            end
        end
    end

    // Avalon-MM slave: one wait state per access
    wire acc = avs_read_i | avs_write_i;
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h00000000;
            ctrl              <= `SSS_CTRL_RST;
        end else begin
            avs_waitrequest_o <= ~(acc & avs_waitrequest_o);
            if (avs_write_i && !avs_waitrequest_o &&
                    avs_address_i == `SSS_OFS_CTRL &&
                    avs_byteenable_i[0]) begin
                ctrl <= avs_writedata_i[7:0];
            end
            if (avs_read_i && avs_waitrequest_o) begin
                avs_readdata_o <= 32'h00000000;
                case (avs_address_i)
                    `SSS_OFS_CTRL:
                        avs_readdata_o[7:0] <= ctrl;
                    `SSS_OFS_STATUS: begin
                        avs_readdata_o[`SSS_ST_STATE_MSB:
                            `SSS_ST_STATE_LSB] <= state;
                        avs_readdata_o[`SSS_ST_SLOT_MSB:
                            `SSS_ST_SLOT_LSB] <= slot;
                        avs_readdata_o[`SSS_ST_MODE_BIT] <= mode_l;
                        avs_readdata_o[`SSS_ST_SEL_MSB:
                            `SSS_ST_SEL_LSB] <= sel_l;
                        avs_readdata_o[`SSS_ST_DONE_BIT] <= done_ok;
                        avs_readdata_o[`SSS_ST_ERR_BIT]  <= done_err;
                        avs_readdata_o[`SSS_ST_INH_BIT]  <=
                            data_store_inhibit_o;
                        avs_readdata_o[`SSS_ST_EOSN_MSB:
                            `SSS_ST_EOSN_LSB] <= eos_cnt;
                    end
                    `SSS_OFS_COUNT:
                        avs_readdata_o[15:0] <= seq_count;
                    default:
                        avs_readdata_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

/* File: tb/sss_scan_sequencer_assertions.sv */
// Port-level concurrent checks for the scan sequencer
`timescale 1ns/1ps
`default_nettype none
module sss_scan_sequencer_checker #(
    parameter NCH = 8
) (
    input wire logic           sys_clk_i,
    input wire logic           rst_b_i,
    input wire logic           secondary_clock_in_i,
    input wire logic [NCH-1:0] sensor_scan_end_n_i,
    input wire logic           avs_read_i,
    input wire logic           avs_write_i,
    input wire logic           scan_end_out_n_o,
    input wire logic           data_store_inhibit_o,
    input wire logic           type_ident_bit0_o,
    input wire logic           type_ident_bit1_o,
    input wire logic [NCH-1:0] sensor_pixel_clock_o,
    input wire logic           avs_waitrequest_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    chk_ident_zero_low: assert property (!type_ident_bit0_o)
        else $error("ident bit0 not low");
    chk_ident_one_low: assert property (!type_ident_bit1_o)
        else $error("ident bit1 not low");
    chk_wait_drops: assert property ((avs_read_i || avs_write_i)
        && avs_waitrequest_o |-> ##[1:2] !avs_waitrequest_o)
        else $error("waitrequest never dropped");
    chk_wait_single: assert property ($fell(avs_waitrequest_o)
        |=> avs_waitrequest_o) else $error("waitrequest low too long");
    chk_wait_idle: assert property (!(avs_read_i || avs_write_i)
        && !$past(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
        else $error("waitrequest low without request");
    chk_inhibit_cause: assert property ($rose(data_store_inhibit_o) |->
        !$past(sensor_scan_end_n_i[0], 1) || !$past(sensor_scan_end_n_i[0], 2)
        || !$past(sensor_scan_end_n_i[0], 3))
        else $error("inhibit without start channel end");
    chk_end_cause: assert property ($fell(scan_end_out_n_o) |->
        $past(sensor_scan_end_n_i) != '1)
        else $error("end pulse without sensor end");
    chk_clock_cause: assert property (|sensor_pixel_clock_o |->
        $past(secondary_clock_in_i))
        else $error("pixel clock without front end clock");
    chk_clock_shape: assert property (|sensor_pixel_clock_o |->
        $onehot(sensor_pixel_clock_o) || &sensor_pixel_clock_o)
        else $error("pixel clock on several channels");
endmodule
bind sss_scan_sequencer sss_scan_sequencer_checker #(.NCH(NCH)) u_chk (
    .sys_clk_i, .rst_b_i, .secondary_clock_in_i, .sensor_scan_end_n_i,
    .avs_read_i, .avs_write_i, .scan_end_out_n_o, .data_store_inhibit_o,
    .type_ident_bit0_o, .type_ident_bit1_o, .sensor_pixel_clock_o,
    .avs_waitrequest_o);
`default_nettype wire

/* File: tb/sss_front_end_model.sv */
// Front-end scan controller: clock, start, latch strobe, mode and selects
`timescale 1ns/1ps
`default_nettype none
module sss_front_end_model (
    input wire logic        clk_i,
    input wire logic        run_i,
    input wire logic        start_req_i,
    input wire logic        latch_req_i,
    input wire logic        mode_req_i,
    input wire logic [2:0]  sel_req_i,
    output logic            pix_o,
    output logic            start_o,
    output logic            strobe_o,
    output logic            mode_o,
    output logic [2:0]      sel_o
);
    logic [1:0] cnt = 2'h0;
    initial {pix_o, start_o, strobe_o, mode_o, sel_o} = 7'h00;
    // Clock stands low between frames so stray edges cannot clock a sensor
    always @(posedge clk_i) begin
        cnt <= cnt + 2'h1;
        pix_o <= run_i & cnt[1];
        start_o <= start_req_i;
        strobe_o <= latch_req_i;
        if (latch_req_i) begin
            mode_o <= mode_req_i;
            sel_o <= sel_req_i;
        end
    end
endmodule
`default_nettype wire

/* File: tb/sss_scan_sequencer_bench.sv */
// Self-checking bench for the scan sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sss_regs.vh"
module sss_scan_sequencer_bench;
    logic clk = 0, rst_b = 0, run = 0, start_req = 0, latch_req = 0;
    logic mode_req = 0, rd = 0, wr = 0, end_q = 1, inh_seen = 0;
    logic [2:0] sel_req = 0;
    logic [3:0] adr = 0;
    logic [31:0] wdat = 0, q;
    logic [7:0] eos_n = 8'hff, pclk_q = 0;
    wire pix, start, strobe, mode, end_n, inh, id0, id1, wait_o;
    wire [2:0] sel, vaddr;
    wire [7:0] beg, pclk;
    wire [31:0] rdat;
    int failures = 0, n_tests = 0, neos = 0, pc[8];
    always #5 clk = ~clk;
    sss_front_end_model fe (.clk_i(clk), .run_i(run), .start_req_i(start_req),
        .latch_req_i(latch_req), .mode_req_i(mode_req), .sel_req_i(sel_req),
        .pix_o(pix), .start_o(start), .strobe_o(strobe), .mode_o(mode),
        .sel_o(sel));
    sss_scan_sequencer dut (.sys_clk_i(clk), .rst_b_i(rst_b),
        .scan_start_i(start), .config_latch_strobe_i(strobe),
        .scan_mode_select_i(mode), .channel_select_bit0_i(sel[0]),
        .channel_select_bit1_i(sel[1]), .channel_select_bit2_i(sel[2]),
        .secondary_clock_in_i(pix), .scan_end_out_n_o(end_n),
        .data_store_inhibit_o(inh), .type_ident_bit0_o(id0),
        .type_ident_bit1_o(id1), .video_select_addr_o(vaddr),
        .sensor_scan_begin_o(beg), .sensor_pixel_clock_o(pclk),
        .sensor_scan_end_n_i(eos_n), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o));
    always @(posedge clk) begin
        end_q <= end_n;
        pclk_q <= pclk;
        if (inh) inh_seen <= 1;
        if (end_q && !end_n) neos++;
        for (int i = 0; i < 8; i++) if (pclk[i] && !pclk_q[i]) pc[i]++;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task conclude;
        if (failures == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        adr <= a; wdat <= d; rd <= !w; wr <= w;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (wait_o === 1'b0) break;
        end
        if (k == 20) begin failures++; conclude; end
        q = rdat;
        rd <= 0; wr <= 0;
    endtask
    task cfg(input logic m, input logic [2:0] s);
        @(posedge clk);
        mode_req <= m; sel_req <= s; latch_req <= 1;
        @(posedge clk);
        latch_req <= 0;
        cyc(4);
    endtask
    task go;
        for (int i = 0; i < 8; i++) pc[i] = 0;
        neos = 0; inh_seen = 0;
        @(posedge clk);
        start_req <= 1;
        cyc(2);
        start_req <= 0; run <= 1;
    endtask
    task t_regs;
        check({id1, id0, end_n, inh, wait_o}, 5'h05);
        bus(0, `SSS_OFS_CTRL, 0); check(q, 32'h1);
        bus(0, 4'hc, 0); check(q, 32'h0);
        bus(1, `SSS_OFS_STATUS, 32'hffffffff);
        bus(0, `SSS_OFS_STATUS, 0); check(q[2:0], `SSS_S_IDLE);
        bus(1, `SSS_OFS_CTRL, 0); bus(0, `SSS_OFS_CTRL, 0); check(q, 32'h0);
        bus(1, `SSS_OFS_CTRL, 1);
    endtask
    task t_seq;
        for (int k = 0; k < 8; k++) begin
            cfg(0, k[2:0]); check(vaddr, k);
            eos_n <= ~(8'h01 << k); cyc(3); check(end_n, 0);
            eos_n <= ~(8'h01 << ((k + 1) % 8)); cyc(3); check(end_n, 1);
            eos_n <= 8'hff;
        end
        run <= 1;
        for (int k = 0; k < 20 && pclk == 0; k++) cyc(1);
        check(pclk, 8'hff);
        run <= 0;
    endtask
    // Hold the first nok channel ends low; success only if all active report
    task t_sim(input int s, input int nok);
        cfg(1, s[2:0]); go; cyc(80);
        check(pc[s] > 0 && pc[0] - pc[s] <= 1, 1);
        if (s < 7) check(pc[s + 1], 0);
        eos_n <= ~8'((1 << nok) - 1);
        cyc(150);
        eos_n <= 8'hff; run <= 0; cyc(4);
        check(inh_seen, 1);
        check(neos, nok);
        bus(0, `SSS_OFS_STATUS, 0); check(q[2:0], `SSS_S_IDLE);
        check(q[17:16], nok == s + 1 ? 2'h1 : 2'h2);
    endtask
    initial begin
        #900000;
        failures++;
        conclude;
    end
    initial begin
        cyc(10);
        rst_b <= 1;
        t_regs;
        t_seq;
        t_sim(1, 2); t_sim(2, 2); t_sim(7, 8);
        bus(0, `SSS_OFS_COUNT, 0); check(q[15:0], 16'h3);
        bus(1, `SSS_OFS_CTRL, 0); cfg(1, 3'h1); go; cyc(40); run <= 0;
        check(pc[0], 0);
        conclude;
    end
endmodule
`default_nettype wire
